// >>> pkg/pdc_defs.svh
/*
  Constants for the preset down counter: register offsets, field positions,
  reset values and limits. Assumes inclusion by bare name from the package.
*/
`ifndef PDC_DEFS_SVH
`define PDC_DEFS_SVH

`define PDC_NUM_CNT        4
`define PDC_IDX_W          2
`define PDC_MAX_INST       1024
`define PDC_SV_MAX         16'h7FFF
`define PDC_SV_MIN_SELF    16'h0001
`define PDC_SV_MIN_NUM     16'h0000

`define PDC_OFF_CTRL       8'h00
`define PDC_OFF_COUNT_IN   8'h04
`define PDC_OFF_RESET_IN   8'h08
`define PDC_OFF_HOLD       8'h0C
`define PDC_OFF_BOUNDARY   8'h10
`define PDC_OFF_ZERO       8'h14
`define PDC_OFF_IRQ_STAT   8'h18
`define PDC_OFF_IRQ_MASK   8'h1C
`define PDC_OFF_PRESET0    8'h20
`define PDC_OFF_ELAPSED0   8'h40

`define PDC_CTRL_MODE_RUN  0
`define PDC_CTRL_VARIANT   1

`define PDC_CTRL_RST       2'h0
`define PDC_PRESET_RST     16'h000A
`define PDC_HOLD_RST       4'hF
`define PDC_BOUNDARY_RST   10'h000

`endif

// >>> pkg/pdc_pkg.sv
/*
  Types for the preset down counter. Assumes the constants header is on the
  include path.
*/
package pdc_pkg;
  `include "pdc_defs.svh"

  typedef struct packed {
    logic count;
    logic reset;
  } pdc_in_t;

  typedef struct packed {
    logic [15:0] elapsed;
    logic        zero;
  } pdc_state_t;

  typedef enum logic [1:0] {
    PDC_IDLE = 2'b00,
    PDC_DATA = 2'b01,
    PDC_RESP = 2'b11
  } pdc_wr_st_t;
endpackage

// >>> src/pdc_top.sv
/*
  Pool of preset down counters with AXI4-Lite register access.
  Assumes one sys_clk edge per program scan; count and reset come from logic on the same clock.
*/
`timescale 1ns/1ps
module pdc_top
  import pdc_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  // Write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // Write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // Write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // Read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // Read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Counter inputs and outputs
  input  wire pdc_in_t [`PDC_NUM_CNT-1:0] cnt_in,
  output logic [`PDC_NUM_CNT-1:0]          zero_reached,
  output logic                             irq
);

  // Pool size is fixed; the package constants size every per-counter vector
  localparam int N = `PDC_NUM_CNT;

  // Returns register index of a preset or elapsed slot, or N when none
  function automatic logic [2:0] slot_idx(input logic [7:0] a, input logic [7:0] base);
    logic [7:0] d;
    d = a - base;
    if (a >= base && d < 8'(4*N) && d[1:0] == 2'b00)
      slot_idx = {1'b0, d[3:2]};
    else
      slot_idx = 3'h4;
  endfunction

  // True for every mapped offset; drives the response code
  function automatic logic known_addr(input logic [7:0] a);
    logic [2:0] p_idx;
    logic [2:0] e_idx;
    p_idx = slot_idx(a, `PDC_OFF_PRESET0);
    e_idx = slot_idx(a, `PDC_OFF_ELAPSED0);
    known_addr = (a == `PDC_OFF_CTRL) || (a == `PDC_OFF_COUNT_IN) || (a == `PDC_OFF_RESET_IN) ||
                 (a == `PDC_OFF_HOLD) || (a == `PDC_OFF_BOUNDARY) || (a == `PDC_OFF_ZERO) ||
                 (a == `PDC_OFF_IRQ_STAT) || (a == `PDC_OFF_IRQ_MASK) ||
                 !p_idx[2] || !e_idx[2];
  endfunction

  // Software-visible control; ctrl_q[1] set lets a zero preset through
  logic [1:0]    ctrl_q;
  logic [N-1:0]  sw_count_q;
  logic [N-1:0]  sw_reset_q;
  logic [N-1:0]  hold_q;
  logic [9:0]    boundary_q;
  logic [N-1:0]  irq_stat_q;
  logic [N-1:0]  irq_mask_q;
  logic [15:0]   preset_q [N];
  logic [N-1:0]  preset_err_q;

  // Write channel
  pdc_wr_st_t    wr_st_q;
  logic [7:0]    awaddr_q;
  logic          aw_have_q;
  logic [31:0]   wdata_q;
  logic          w_have_q;
  logic          wr_fire;
  logic          wr_ok;
  logic [2:0]    wr_pidx;
  logic          run_prev_q;
  logic          run_to_prog;
  logic          wstrb_nz_q;
  logic          reg_we;

  // Commit lands on the edge that raises bvalid, so a later read sees it
  assign wr_fire     = (wr_st_q == PDC_RESP) && !s_axi_bvalid;
  // The elapsed area is read only; writes to it get SLVERR
  assign wr_ok       = known_addr(awaddr_q) && (awaddr_q < `PDC_OFF_ELAPSED0);
  assign reg_we      = wr_fire && wr_ok && wstrb_nz_q;
  assign wr_pidx     = slot_idx(awaddr_q, `PDC_OFF_PRESET0);
  // Mode change is seen one scan after the control write lands
  assign run_to_prog = run_prev_q && !ctrl_q[`PDC_CTRL_MODE_RUN];

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_st_q       <= PDC_IDLE;
      awaddr_q      <= 8'h00;
      aw_have_q     <= 1'b0;
      wdata_q       <= 32'h0000_0000;
      w_have_q      <= 1'b0;
      wstrb_nz_q    <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
    end else begin
      // Address and data may come in either order; each is kept until the response is taken
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      case (wr_st_q)
        PDC_IDLE: begin
          if (s_axi_awvalid && !aw_have_q && !s_axi_awready) begin
            s_axi_awready <= 1'b1;
            awaddr_q      <= s_axi_awaddr;
            aw_have_q     <= 1'b1;
          end
          if (s_axi_wvalid && !w_have_q && !s_axi_wready) begin
            s_axi_wready <= 1'b1;
            wdata_q      <= s_axi_wdata;
            wstrb_nz_q   <= (s_axi_wstrb != 4'h0);
            w_have_q     <= 1'b1;
          end
          if (aw_have_q && w_have_q) begin
            wr_st_q <= PDC_DATA;
          end
        end
        PDC_DATA: begin
          wr_st_q <= PDC_RESP;
        end
        PDC_RESP: begin
          // Registers update on the cycle bvalid rises
          if (!s_axi_bvalid) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? 2'h0 : 2'h2;
          end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_have_q    <= 1'b0;
            w_have_q     <= 1'b0;
            wr_st_q      <= PDC_IDLE;
          end
        end
        default: wr_st_q <= PDC_IDLE;
      endcase
    end
  end

  // Byte enables are honoured at register granularity: any strobe writes the word
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q     <= `PDC_CTRL_RST;
      sw_count_q <= '0;
      sw_reset_q <= '0;
      hold_q     <= `PDC_HOLD_RST;
      boundary_q <= `PDC_BOUNDARY_RST;
      irq_mask_q <= '0;
      run_prev_q <= 1'b0;
    end else begin
      run_prev_q <= ctrl_q[`PDC_CTRL_MODE_RUN];
      if (reg_we) begin
        case (awaddr_q)
          `PDC_OFF_CTRL:     ctrl_q     <= wdata_q[1:0];
          `PDC_OFF_COUNT_IN: sw_count_q <= wdata_q[N-1:0];
          `PDC_OFF_RESET_IN: sw_reset_q <= wdata_q[N-1:0];
          `PDC_OFF_HOLD:     hold_q     <= wdata_q[N-1:0];
          // Stored for the program only; this pool has no numbering to police
          `PDC_OFF_BOUNDARY: boundary_q <= wdata_q[9:0];
          `PDC_OFF_IRQ_MASK: irq_mask_q <= wdata_q[N-1:0];
          default: ;
        endcase
      end
    end
  end

  // Preset stores: out-of-range values are refused and flagged
  // A refused value keeps the old preset, so a bad write never leaves
  // the counter without a valid reload value
  genvar gp;
  generate
    for (gp = 0; gp < N; gp++) begin : g_preset
      logic [15:0] lo;
      // Lower bound follows the variant: the numbered form accepts zero
      assign lo = ctrl_q[`PDC_CTRL_VARIANT] ? `PDC_SV_MIN_NUM : `PDC_SV_MIN_SELF;
      always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
          preset_q[gp]     <= `PDC_PRESET_RST;
          preset_err_q[gp] <= 1'b0;
        end else if (reg_we && wr_pidx == 3'(gp)) begin
          if (wdata_q[15:0] >= lo && wdata_q[15:0] <= `PDC_SV_MAX) begin
            preset_q[gp]     <= wdata_q[15:0];
            preset_err_q[gp] <= 1'b0;
          end else begin
            preset_err_q[gp] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  // Counter cores, one scan per clock
  logic [N-1:0]  cnt_prev_q;
  logic [N-1:0]  rst_prev_q;
  logic [15:0]   elapsed_q [N];
  logic [N-1:0]  zero_q;
  logic [N-1:0]  zero_rise;

  genvar gc;
  generate
    for (gc = 0; gc < N; gc++) begin : g_cnt
      logic cnt_lvl;
      logic rst_lvl;
      logic cnt_rise;
      logic rst_fall;
      // Pin and software levels are ORed, so either source makes a scan edge
      assign cnt_lvl  = cnt_in[gc].count | sw_count_q[gc];
      assign rst_lvl  = cnt_in[gc].reset | sw_reset_q[gc];
      assign cnt_rise = cnt_lvl && !cnt_prev_q[gc];
      assign rst_fall = !rst_lvl && rst_prev_q[gc];
      assign zero_rise[gc] = !zero_q[gc] && !rst_lvl && !rst_fall && cnt_rise && elapsed_q[gc] == 16'h0001;

      always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
          // Edge history resets to the idle low level, so no false edge follows reset
          cnt_prev_q[gc] <= 1'b0;
          rst_prev_q[gc] <= 1'b0;
          elapsed_q[gc]  <= 16'h0000;
          zero_q[gc]     <= 1'b0;
        end else begin
          cnt_prev_q[gc] <= cnt_lvl;
          rst_prev_q[gc] <= rst_lvl;
          // Order: mode clear, reset level, reset fall, count edge; a count edge meeting reset is lost
          if (run_to_prog && !hold_q[gc]) begin
            elapsed_q[gc] <= 16'h0000;
            zero_q[gc]    <= 1'b0;
          end else if (rst_lvl) begin
            elapsed_q[gc] <= 16'h0000;
            zero_q[gc]    <= 1'b0;
          end else if (rst_fall) begin
            elapsed_q[gc] <= preset_q[gc];
          end else if (cnt_rise && elapsed_q[gc] != 16'h0000) begin
            elapsed_q[gc] <= elapsed_q[gc] - 16'h0001;
            if (elapsed_q[gc] == 16'h0001) begin
              zero_q[gc] <= 1'b1;
            end
          end
        end
      end
    end
  endgenerate

  assign zero_reached = zero_q;

  // Sticky zero-reached events; set wins over write-one-to-clear
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_stat_q <= '0;
      irq        <= 1'b0;
    end else begin
      if (reg_we && awaddr_q == `PDC_OFF_IRQ_STAT)
        irq_stat_q <= (irq_stat_q & ~wdata_q[N-1:0]) | zero_rise;
      else
        irq_stat_q <= irq_stat_q | zero_rise;
      // One clock of lag buys an output straight from a flop
      irq <= |(irq_stat_q & irq_mask_q);
    end
  end

  // Read channel, data registered on the same edge that takes the address
  logic [31:0] rd_mux;
  logic [2:0]  rd_pidx;
  logic [2:0]  rd_eidx;
  assign rd_pidx = slot_idx(s_axi_araddr, `PDC_OFF_PRESET0);
  assign rd_eidx = slot_idx(s_axi_araddr, `PDC_OFF_ELAPSED0);

  // Decode is combinational on araddr; the answer is registered with arready
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (s_axi_araddr)
      `PDC_OFF_CTRL:     rd_mux = {30'h0, ctrl_q};
      `PDC_OFF_COUNT_IN: rd_mux = {{(32-N){1'b0}}, sw_count_q};
      `PDC_OFF_RESET_IN: rd_mux = {{(32-N){1'b0}}, sw_reset_q};
      `PDC_OFF_HOLD:     rd_mux = {{(32-N){1'b0}}, hold_q};
      `PDC_OFF_BOUNDARY: rd_mux = {22'h0, boundary_q};
      `PDC_OFF_ZERO:     rd_mux = {{(32-2*N){1'b0}}, preset_err_q, zero_q};
      `PDC_OFF_IRQ_STAT: rd_mux = {{(32-N){1'b0}}, irq_stat_q};
      `PDC_OFF_IRQ_MASK: rd_mux = {{(32-N){1'b0}}, irq_mask_q};
      default: begin
        if (!rd_pidx[2])
          rd_mux = {16'h0, preset_q[rd_pidx[1:0]]};
        else if (!rd_eidx[2])
          rd_mux = {16'h0, elapsed_q[rd_eidx[1:0]]};
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
    end else begin
      s_axi_arready <= 1'b0;
      // Data is taken with the address, so it stands unchanged while rvalid waits
      if (s_axi_rvalid) begin
        if (s_axi_rready)
          s_axi_rvalid <= 1'b0;
      end else if (s_axi_arvalid && !s_axi_arready) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_mux;
        s_axi_rresp   <= known_addr(s_axi_araddr) ? 2'h0 : 2'h2;
      end
    end
  end

endmodule // pdc_top

// >>> sim/pdc_top_chk.sv
/* Checker for pdc_top: bus handshakes and counter 0 flag timing.
   Assumes bind to pdc_top, that the contact registers stay clear and that
   counter 0 has its flag low whenever a mode change clears it. */
`timescale 1ns/1ps
`include "pdc_defs.svh"
module pdc_top_chk
  import pdc_pkg::*;
(
  // Clock and reset
  input wire logic          sys_clk,
  input wire logic          arst_n,
  // Bus
  input wire logic          s_axi_awready,
  input wire logic          s_axi_bvalid,
  input wire logic          s_axi_bready,
  input wire logic [1:0]    s_axi_bresp,
  input wire logic          s_axi_arready,
  input wire logic          s_axi_rvalid,
  input wire logic          s_axi_rready,
  input wire logic [31:0]   s_axi_rdata,
  // Counters
  input wire pdc_in_t [3:0] cnt_in,
  input wire logic [3:0]    zero_reached,
  input wire logic          irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  logic [2:0] rise_q;
  logic       cnt_q;
  // The flag may only follow a recent count edge, never a reset or a preset load
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q  <= 1'b0;
      rise_q <= 3'h0;
    end else begin
      cnt_q  <= cnt_in[0].count;
      rise_q <= {rise_q[1:0], cnt_in[0].count & ~cnt_q};
    end
  end
  a_rst_clears_zero: assert property (cnt_in[0].reset [*3] |-> !zero_reached[0])
    else $error("zero flag high under held reset");
  a_rst_wins: assert property (cnt_in[0].reset |=> !zero_reached[0])
    else $error("zero flag set while reset high");
  a_zero_sticky: assert property (zero_reached[0] && !cnt_in[0].reset |=> zero_reached[0])
    else $error("zero flag dropped without reset");
  a_zero_cause: assert property ($rose(zero_reached[0]) |-> |rise_q)
    else $error("zero flag rose without a count edge");
  a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready longer than one cycle");
  a_b_follows: assert property ($rose(s_axi_awready) |-> ##[1:8] s_axi_bvalid)
    else $error("write response missing");
  a_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
  a_r_with_ar: assert property (s_axi_arready |-> s_axi_rvalid)
    else $error("read data not with address accept");
  a_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  a_b_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_r_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response repeated");
  c_zero: cover property ($rose(zero_reached[0]));
  c_irq: cover property ($rose(irq));
  c_both: cover property (cnt_in[0].count && cnt_in[0].reset);
endmodule // pdc_top_chk

bind pdc_top pdc_top_chk u_chk (.*);

// >>> sim/pdc_prog_model.sv
/* Model of the user program driving the count and reset contacts.
   Assumes the bench calls its tasks; levels change just after a sys_clk edge. */
`timescale 1ns/1ps
`include "pdc_defs.svh"
module pdc_prog_model
  import pdc_pkg::*;
(
  // Clock
  input wire logic     sys_clk,
  // Contacts
  output pdc_in_t [3:0] cnt_in
);
  initial cnt_in = '0;
  // One level per scan; the counter sees a change between scans as an edge
  task automatic drive(input int k, input logic c, input logic r);
    @(posedge sys_clk);
    cnt_in[k] <= '{count: c, reset: r};
  endtask
  // Elapsed count is only valid after a full reset pulse
  task automatic restart(input int k);
    drive(k, 1'b0, 1'b1);
    drive(k, 1'b0, 1'b1);
    drive(k, 1'b0, 1'b0);
  endtask
  task automatic pulses(input int k, input int n);
    repeat (n) begin
      drive(k, 1'b1, 1'b0);
      drive(k, 1'b0, 1'b0);
    end
  endtask
endmodule // pdc_prog_model

// >>> sim/pdc_top_tb.sv
/* Self-checking bench for pdc_top: bus tasks, program model, random counts.
   Assumes the register map and counter pool of pdc_pkg. */
`timescale 1ns/1ps
`include "pdc_defs.svh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin error_cnt++; $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module pdc_top_tb
  import pdc_pkg::*;
;
  logic               sys_clk, arst_n;
  logic [7:0]         s_axi_awaddr, s_axi_araddr;
  logic [31:0]        s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]         s_axi_wstrb, zero_reached;
  logic [1:0]         s_axi_bresp, s_axi_rresp, rs;
  logic               s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic               s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq;
  wire pdc_in_t [3:0] cnt_in;
  logic [15:0]        p;
  int                 n, error_cnt, check_count;

  pdc_top dut (
    .sys_clk       (sys_clk),
    .arst_n        (arst_n),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .cnt_in        (cnt_in),
    .zero_reached  (zero_reached),
    .irq           (irq)
  );
  pdc_prog_model prog (.sys_clk(sys_clk), .cnt_in(cnt_in));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    rs = s_axi_bresp;
  endtask

  // Ready stands from the request on; the answer is taken at the edge that shows valid
  task automatic rd_reg(input logic [7:0] a);
    @(posedge sys_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    rs = s_axi_rresp;
  endtask

  task automatic expect_rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    rd_reg(a);
    `CHK(nm, e, rd)
  endtask

  function automatic logic [15:0] exp_left(input logic [15:0] pv, input int cnt);
    return (cnt >= int'(pv)) ? 16'h0000 : pv - 16'(cnt);
  endfunction

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    $display("[FAIL] watchdog exp done got timeout");
    test_done();
  end

  initial begin
    error_cnt   = 0;
    check_count = 0;
    arst_n      = 1'b0;
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    void'($urandom(68));
    repeat (2) @(posedge sys_clk);
    arst_n <= 1'b1;
    expect_rd("preset0", `PDC_OFF_PRESET0, 32'h0000000A);
    expect_rd("hold", `PDC_OFF_HOLD, 32'h0000000F);
    expect_rd("elapsed0", `PDC_OFF_ELAPSED0, 32'h00000000);
    rd_reg(8'h80);
    `CHK("unmapped", 2'h2, rs)
    `CHK("unmapped data", 32'h00000000, rd)
    // Boundary 0 keeps every counter number of the pool in range
    wr(`PDC_OFF_BOUNDARY, 32'hFFFFFC00);
    expect_rd("boundary", `PDC_OFF_BOUNDARY, 32'h00000000);
    $display("test regs done");
    for (int k = 0; k < 4; k++) begin
      p = 16'($urandom_range(1, 6));
      n = $urandom_range(0, 8);
      wr(`PDC_OFF_PRESET0 + 8'(4 * k), {16'h0000, p});
      prog.restart(k);
      expect_rd("loaded", `PDC_OFF_ELAPSED0 + 8'(4 * k), {16'h0000, p});
      prog.pulses(k, n);
      expect_rd("elapsed", `PDC_OFF_ELAPSED0 + 8'(4 * k), {16'h0000, exp_left(p, n)});
      `CHK("zero", 1'(n >= int'(p)), zero_reached[k])
    end
    wr(`PDC_OFF_PRESET0 + 8'h04, 32'h00000001);
    prog.restart(1);
    prog.pulses(1, 3);
    expect_rd("floor", `PDC_OFF_ELAPSED0 + 8'h04, 32'h00000000);
    `CHK("zero1", 1'b1, zero_reached[1])
    $display("test counting done");
    wr(`PDC_OFF_PRESET0, 32'h00000001);
    prog.restart(0);
    prog.drive(0, 1'b1, 1'b1);
    prog.drive(0, 1'b0, 1'b1);
    `CHK("rst wins", 1'b0, zero_reached[0])
    wr(`PDC_OFF_PRESET0, 32'h00007FFF);
    prog.restart(0);
    expect_rd("max", `PDC_OFF_ELAPSED0, 32'h00007FFF);
    prog.drive(0, 1'b1, 1'b1);
    prog.drive(0, 1'b1, 1'b1);
    expect_rd("held", `PDC_OFF_ELAPSED0, 32'h00000000);
    `CHK("cleared", 1'b0, zero_reached[0])
    prog.drive(0, 1'b0, 1'b1);
    prog.drive(0, 1'b1, 1'b0);
    expect_rd("fall", `PDC_OFF_ELAPSED0, 32'h00007FFF);
    $display("test priority done");
    wr(`PDC_OFF_PRESET0, 32'h00000000);
    expect_rd("zero refused", `PDC_OFF_PRESET0, 32'h00007FFF);
    wr(`PDC_OFF_PRESET0, 32'h00008000);
    expect_rd("high refused", `PDC_OFF_PRESET0, 32'h00007FFF);
    rd_reg(`PDC_OFF_ZERO);
    `CHK("preset err", 1'b1, rd[4])
    // Variant changes only once counting is over, so the pool never mixes both
    wr(`PDC_OFF_CTRL, 32'h00000002);
    wr(`PDC_OFF_PRESET0, 32'h00000000);
    expect_rd("zero taken", `PDC_OFF_PRESET0, 32'h00000000);
    $display("test preset range done");
    wr(`PDC_OFF_HOLD, 32'h0000000E);
    wr(`PDC_OFF_CTRL, 32'h00000003);
    wr(`PDC_OFF_CTRL, 32'h00000002);
    expect_rd("mode clear", `PDC_OFF_ELAPSED0, 32'h00000000);
    `CHK("mode hold", 1'b1, zero_reached[1])
    $display("test mode change done");
    wr(`PDC_OFF_IRQ_MASK, 32'h00000000);
    repeat (3) @(posedge sys_clk);
    `CHK("irq masked", 1'b0, irq)
    wr(`PDC_OFF_IRQ_MASK, 32'hFFFFFFFF);
    repeat (3) @(posedge sys_clk);
    `CHK("irq open", 1'b1, irq)
    wr(`PDC_OFF_IRQ_STAT, 32'hFFFFFFFF);
    repeat (3) @(posedge sys_clk);
    `CHK("irq cleared", 1'b0, irq)
    $display("test irq done");
    test_done();
  end
endmodule // pdc_top_tb
